//--- include/sost_pkg.sv
package sost_pkg;

  // serial control word: address first, then data, both lsb first
  localparam int unsigned SER_ADDR_W  = 12;
  localparam int unsigned SER_DATA_W  = 28;
  localparam int unsigned SER_WORD_W  = SER_ADDR_W + SER_DATA_W;
  localparam logic [5:0]  SER_CNT_FULL = 6'h28;
  localparam logic [5:0]  SER_CNT_OVER = 6'h29;

  localparam logic [11:0] ADDR_SOURCE_SELECT = 12'h060;
  localparam logic [11:0] ADDR_TRIGGER       = 12'h061;

  localparam int unsigned SEL_W   = 3;
  localparam int unsigned NUM_SEL = 4;
  localparam int unsigned TRIG_W  = 8;

  // selector field positions inside the source-select register
  localparam int unsigned POS_BIAS_SEL  = 0;
  localparam int unsigned POS_MECH_SEL  = 3;
  localparam int unsigned POS_STROBE_SEL = 6;
  localparam int unsigned POS_TEST_SEL  = 9;

  // trigger bit positions
  localparam int unsigned TRIG_ALL_SHUT  = 0;
  localparam int unsigned TRIG_SHUTTER_GEN_1     = 1;
  localparam int unsigned TRIG_SHUTTER_GEN_2     = 2;
  localparam int unsigned TRIG_SHUTTER_GEN_3     = 3;
  localparam int unsigned TRIG_SUB_A     = 4;
  localparam int unsigned TRIG_SUB_B     = 5;
  localparam int unsigned TRIG_EXPOSURE  = 6;
  localparam int unsigned TRIG_READOUT   = 7;

  localparam logic [11:0] RST_SOURCE_SELECT = 12'h000;
  localparam logic [7:0]  RST_TRIGGER       = 8'h00;

  // source codes
  localparam logic [2:0] SRC_SHUTTER_GEN_0    = 3'h0;
  localparam logic [2:0] SRC_SHUTTER_GEN_1    = 3'h1;
  localparam logic [2:0] SRC_SHUTTER_GEN_2    = 3'h2;
  localparam logic [2:0] SRC_SHUTTER_GEN_3    = 3'h3;
  localparam logic [2:0] SRC_SUB_A    = 3'h4;
  localparam logic [2:0] SRC_SUB_B    = 3'h5;
  localparam logic [2:0] SRC_INVALID  = 3'h6;
  localparam logic [2:0] SRC_COMBINED = 3'h7;

  typedef struct packed {
    logic       sl;
    logic       sck;
    logic       sdata;
  } sost_serial_s;

  typedef struct packed {
    logic [3:0] shutter_gen;
    logic       substrate_mux_a;
    logic       substrate_mux_b;
    logic       combined_shutter_mux;
  } sost_sources_s;

  typedef struct packed {
    logic substrate_bias_pin;
    logic mechanical_shutter_pin;
    logic strobe_pin;
    logic test_output;
  } sost_pins_s;

  typedef struct packed {
    logic [3:0] shutter_start;
    logic       substrate_pulse_a_start;
    logic       substrate_pulse_b_start;
    logic       exposure_start;
    logic       readout_start;
  } sost_starts_s;

  typedef struct packed {
    logic                  sck_prev;
    logic                  sl_prev;
    logic                  vsync_prev;
    logic [SER_WORD_W-1:0] shift;
    logic [5:0]            bit_cnt;
    logic [11:0]           pending_sel;
    logic [11:0]           active_sel;
    logic [7:0]            pending_trig;
    logic                  readout_wait;
    sost_pins_s            pins;
    sost_starts_s          starts;
  } sost_state_s;

endpackage

//--- rtl/sost_top.sv
`timescale 1ns/1ps
// Functional notes
// - Bits 2 to 0 of the source-select register pick the source of the substrate-bias pin.
// - Codes 0 to 3 route shutter generator 0 to 3, each fed by its own parameter set.
// - Code 4 routes substrate mux a and code 5 routes substrate mux b.
// - Code 7 routes the combined shutter mux, and code 6 is invalid and drives the pin low.
// - Bits 5 to 3 pick the source of the mechanical-shutter pin with the same codes.
// - Bits 8 to 6 pick the source of the strobe pin with the same codes.
// - Bits 11 to 9 pick the source of the test output with the same codes.
// - Writing ones into the 8-bit trigger register starts the matching operations.
// - Trigger bit 0 starts all four shutter generators, bits 1 to 3 start one each.
// - Trigger bits 4 and 5 start the substrate pulses a and b, bit 6 starts exposure.
// - Trigger bit 7 starts readout, deferred to the end of exposure when both are set.
module sost_top
  import sost_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire sost_serial_s  ser,
  input  wire logic          vertical_sync,
  input  wire logic          exposure_done,
  input  wire sost_sources_s src,
  output sost_pins_s         pins,
  output sost_starts_s       starts,
  output logic [11:0]        active_select
);

  sost_state_s st;
  sost_state_s next_st;

  logic [NUM_SEL-1:0] routed;
  logic               sck_rise;
  logic               sl_rise;
  logic               vsync_rise;
  logic               word_done;
  logic [11:0]        word_addr;
  logic [27:0]        word_data;

  assign sck_rise   = ser.sck & ~st.sck_prev;
  assign sl_rise    = ser.sl & ~st.sl_prev;
  assign vsync_rise = vertical_sync & ~st.vsync_prev;
  assign word_done  = sl_rise && (st.bit_cnt == SER_CNT_FULL);
  assign word_addr  = st.shift[SER_ADDR_W-1:0];
  assign word_data  = st.shift[SER_WORD_W-1:SER_ADDR_W];

  // one source mux per output, all sharing the code table
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SEL; gi++) begin : g_route
      logic [SEL_W-1:0] code;
      assign code = st.active_sel[gi*SEL_W +: SEL_W];
      always_comb begin
        unique case (code)
          SRC_SHUTTER_GEN_0:    routed[gi] = src.shutter_gen[0];
          SRC_SHUTTER_GEN_1:    routed[gi] = src.shutter_gen[1];
          SRC_SHUTTER_GEN_2:    routed[gi] = src.shutter_gen[2];
          SRC_SHUTTER_GEN_3:    routed[gi] = src.shutter_gen[3];
          SRC_SUB_A:    routed[gi] = src.substrate_mux_a;
          SRC_SUB_B:    routed[gi] = src.substrate_mux_b;
          SRC_COMBINED: routed[gi] = src.combined_shutter_mux;
          SRC_INVALID:  routed[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_comb begin
    next_st            = st;
    next_st.sck_prev   = ser.sck;
    next_st.sl_prev    = ser.sl;
    next_st.vsync_prev = vertical_sync;
    next_st.starts     = '0;

    // serial shifter; a frame longer than one word is dropped whole
    if (ser.sl) begin
      next_st.bit_cnt = '0;
    end else if (sck_rise) begin
      next_st.shift = {ser.sdata, st.shift[SER_WORD_W-1:1]};
      if (st.bit_cnt != SER_CNT_OVER) begin
        next_st.bit_cnt = st.bit_cnt + 6'h01;
      end
    end

    // deferred readout start
    // ahead of the sync step, so a fresh exposure+readout pair landing
    // in the same cycle re-arms the wait instead of being cleared
    if (st.readout_wait && exposure_done) begin
      next_st.readout_wait         = 1'b0;
      next_st.starts.readout_start = 1'b1;
    end

    if (vsync_rise) begin
      next_st.active_sel   = st.pending_sel;
      next_st.pending_trig = '0;
      next_st.starts.shutter_start = {4{st.pending_trig[TRIG_ALL_SHUT]}} |
                                     {st.pending_trig[TRIG_SHUTTER_GEN_3],
                                      st.pending_trig[TRIG_SHUTTER_GEN_2],
                                      st.pending_trig[TRIG_SHUTTER_GEN_1], 1'b0};
      next_st.starts.substrate_pulse_a_start = st.pending_trig[TRIG_SUB_A];
      next_st.starts.substrate_pulse_b_start = st.pending_trig[TRIG_SUB_B];
      next_st.starts.exposure_start          = st.pending_trig[TRIG_EXPOSURE];
      // readout waits for exposure when both are set
      if (st.pending_trig[TRIG_READOUT]) begin
        if (st.pending_trig[TRIG_EXPOSURE]) begin
          next_st.readout_wait = 1'b1;
        end else begin
          next_st.starts.readout_start = 1'b1;
        end
      end
    end

    // a write in the same cycle as sync lands after it, so set beats clear
    if (word_done) begin
      if (word_addr == ADDR_SOURCE_SELECT) begin
        next_st.pending_sel = word_data[11:0];
      end else if (word_addr == ADDR_TRIGGER) begin
        // ones accumulate until the next sync
        next_st.pending_trig = next_st.pending_trig | word_data[TRIG_W-1:0];
      end
    end

    next_st.pins.substrate_bias_pin     = routed[POS_BIAS_SEL / SEL_W];
    next_st.pins.mechanical_shutter_pin = routed[POS_MECH_SEL / SEL_W];
    next_st.pins.strobe_pin             = routed[POS_STROBE_SEL / SEL_W];
    next_st.pins.test_output            = routed[POS_TEST_SEL / SEL_W];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st              <= '0;
      st.sck_prev     <= 1'b0;
      st.sl_prev      <= 1'b1;
      st.pending_sel  <= RST_SOURCE_SELECT;
      st.active_sel   <= RST_SOURCE_SELECT;
      st.pending_trig <= RST_TRIGGER;
    end else begin
      st <= next_st;
    end
  end

  assign pins          = st.pins;
  assign starts        = st.starts;
  assign active_select = st.active_sel;

endmodule

//--- testbench/sost_props.sv
`timescale 1ns/1ps
module sost_props
  import sost_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          vertical_sync,
  input wire logic          exposure_done,
  input wire sost_sources_s src,
  input wire sost_pins_s    pins,
  input wire sost_starts_s  starts,
  input wire logic [11:0]   active_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  function automatic logic pick(logic [2:0] c, sost_sources_s s);
    pick = c < 3'h4 ? s.shutter_gen[c[1:0]] : c == 3'h4 ? s.substrate_mux_a :
      c == 3'h5 ? s.substrate_mux_b : (c == 3'h7) & s.combined_shutter_mux;
  endfunction
  sequence s_was_rise;
    $past(vertical_sync) && !$past(vertical_sync, 2);
  endsequence
  property p_pin(logic o, logic [2:0] c);
    !$past(rst) |-> o == pick($past(c), $past(src));
  endproperty
  a_bias_pin_mux: assert property (p_pin(pins.substrate_bias_pin, active_select[2:0]))
    else $error("bias pin source wrong");
  a_mech_pin_mux: assert property (p_pin(pins.mechanical_shutter_pin, active_select[5:3]))
    else $error("shutter pin source wrong");
  a_strobe_pin_mux: assert property (p_pin(pins.strobe_pin, active_select[8:6]))
    else $error("strobe pin source wrong");
  a_test_out_mux: assert property (p_pin(pins.test_output, active_select[11:9]))
    else $error("test output source wrong");
  a_select_on_sync: assert property ($changed(active_select) |-> s_was_rise)
    else $error("select changed off sync");
  a_starts_on_sync: assert property ((|starts[7:1]) |-> s_was_rise)
    else $error("start pulse off sync");
  a_all_shutters: assert property (starts.shutter_start[0] |-> &starts.shutter_start)
    else $error("bit 0 did not start all");
  a_readout_cause: assert property (starts.readout_start |-> $past(exposure_done)
    || $past(exposure_done, 2) || $past(vertical_sync) && !$past(vertical_sync, 2))
    else $error("readout without cause");
  a_readout_defer: assert property (starts.exposure_start |-> !starts.readout_start)
    else $error("readout not deferred");
endmodule
bind sost_top sost_props u_props (.mclk, .rst, .vertical_sync, .exposure_done, .src, .pins,
  .starts, .active_select);

//--- testbench/sost_partner.sv
`timescale 1ns/1ps
module sost_partner
  import sost_pkg::*;
(
  input  wire logic         mclk,
  input  wire sost_starts_s starts,
  output sost_sources_s     src,
  output logic              exposure_done
);
  logic [3:0] left = 4'h0;
  initial src = 7'h00;
  initial exposure_done = 1'b0;
  // levels move every cycle so a stale route shows
  always @(posedge mclk) begin
    #2;
    src = src + 7'h25;
    exposure_done = left == 4'h1;
    if (starts.exposure_start) left = 4'h6;
    else if (left != 4'h0) left = left - 4'h1;
  end
endmodule

//--- testbench/sost_top_test.sv
`timescale 1ns/1ps
module sost_top_test
  import sost_pkg::*;
;
  logic          mclk, rst, vertical_sync, exposure_done;
  sost_serial_s  ser;
  sost_sources_s src;
  sost_pins_s    pins;
  sost_starts_s  starts, st;
  logic [11:0]   active_select, exp_sel;
  int            n_mismatch = 0, checked = 0, n;
  localparam logic [7:0] EXP_START [8] = '{8'hf0, 8'h20, 8'h40, 8'h80, 8'h08, 8'h04, 8'h02, 8'h01};
  sost_top dut (.mclk, .rst, .ser, .vertical_sync, .exposure_done, .src, .pins, .starts,
    .active_select);
  sost_partner far_side (.mclk, .starts, .src, .exposure_done);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tick(int k = 1);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic chk(logic [11:0] seen, logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [27:0] d);
    logic [39:0] w = {d, a};
    ser.sl = 1'b0;
    tick(2);
    for (int i = 0; i < 40; i++) begin
      ser.sdata = w[i];
      tick(2);
      ser.sck = 1'b1;
      tick(2);
      ser.sck = 1'b0;
    end
    ser.sl = 1'b1;
    tick(2);
  endtask
  task automatic sync();
    vertical_sync = 1'b1;
    tick();
    st = starts;
    vertical_sync = 1'b0;
    tick();
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    vertical_sync = 1'b0;
    ser = 3'h4;
    exp_sel = 12'h000;
    tick(2);
    rst = 1'b0;
    tick();
    chk(active_select, 12'h000);
    for (int c = 0; c < 8; c++) begin
      if (c == 6) continue;
      wr(ADDR_SOURCE_SELECT, {16'h0, {4{c[2:0]}}});
      chk(active_select, exp_sel);
      exp_sel = {4{c[2:0]}};
      sync();
      chk(active_select, exp_sel);
      tick(3);
    end
    wr(ADDR_SOURCE_SELECT, 28'h00005e3);
    // other addresses leave the select alone
    wr(12'h062, 28'h0000fff);
    sync();
    chk(active_select, 12'h5e3);
    tick(3);
    for (int b = 0; b < 8; b++) begin
      wr(ADDR_TRIGGER, 28'h1 << b);
      sync();
      chk({4'h0, st}, {4'h0, EXP_START[b]});
      sync();
      chk({4'h0, st}, 12'h000);
    end
    wr(ADDR_TRIGGER, 28'h02);
    wr(ADDR_TRIGGER, 28'h08);
    sync();
    chk({4'h0, st}, 12'h0a0);
    wr(ADDR_TRIGGER, 28'hc0);
    sync();
    chk({4'h0, st}, 12'h002);
    for (n = 0; n < 20 && starts.readout_start !== 1'b1; n++) tick();
    chk({11'h0, starts.readout_start}, 12'h001);
    finish_test();
  end
endmodule
